/* phy_station_management_tb.sv */
`timescale 1ns/100ps
module phy_station_management_tb;
  import psm_pkg::*;
  logic clk, resetn, reqValid, reqReady, reqRead, reqPreamble, rspValid, regWrite;
  logic [4:0] reqPhy, reqReg, regAddr;
  logic [15:0] reqWdata, rspRdata, regWdata, regRdata;
  logic [15:0] mem [32];
  logic mdcPrev;
  logic inFrame;
  logic bitQ [$];
  int wrCount, nMismatch, samplesChecked;

  psm_link_if link ();
  psm_station psm_station_i (.clk, .resetn, .link, .reqValid, .reqReady, .reqRead,
    .reqPreamble, .reqPhy, .reqReg, .reqWdata, .rspValid, .rspRdata);
  psm_phy psm_phy_i (.clk, .resetn, .link, .regWrite, .regAddr, .regWdata, .regRdata);
  psm_assertions psm_assertions_i (.clk, .resetn, .mdc(link.mdc),
    .mdioStaOut(link.mdioStaOut), .mdioStaOe(link.mdioStaOe),
    .mdioPhyOut(link.mdioPhyOut), .mdioPhyOe(link.mdioPhyOe), .mdio(link.mdio));

  // ====
  // register store behind the phy, line monitor
  always @(posedge clk)
  begin
    if (regWrite === 1'b1)
    begin
      mem[regAddr] <= regWdata;
      wrCount <= wrCount + 1;
    end
    regRdata <= mem[regAddr];
    mdcPrev <= link.mdc;
    if (link.mdioStaOe === 1'b1)
      inFrame <= 1'b1;
    // old values seen here, so the bit is the one held across the rise
    if (link.mdc === 1'b1 && mdcPrev === 1'b0 && (inFrame === 1'b1 || link.mdioStaOe === 1'b1))
      bitQ.push_back(link.mdio);
  end

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic closeOut();
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic drive(input logic rd, input logic pre, input logic [4:0] phy,
    input logic [4:0] rg, input logic [15:0] wd);
    reqRead <= rd;
    reqPreamble <= pre;
    reqPhy <= phy;
    reqReg <= rg;
    reqWdata <= wd;
  endtask

  task automatic xfer(input logic rd, input logic pre, input logic [4:0] phy,
    input logic [4:0] rg, input logic [15:0] wd, input logic [15:0] expData);
    int n;
    logic [31:0] seen;
    int ones;
    int off;
    while (reqReady !== 1'b1)
      @(negedge clk);
    bitQ.delete();
    inFrame <= 1'b0;
    @(posedge clk);
    reqValid <= 1'b1;
    drive(rd, pre, phy, rg, wd);
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    checkWord("response wait", 32'h0, 32'(n >= 600));
    if (rd)
      checkWord("read data", {16'h0, expData}, {16'h0, rspRdata});
    off = pre ? PSM_PREAMBLE_BITS : 0;
    ones = 0;
    for (int i = 0; i < off; i++)
      ones += (bitQ[i] === 1'b1);
    checkWord("preamble", 32'(off), 32'(ones));
    for (int i = 0; i < 32; i++)
      seen[31 - i] = bitQ[off + i];
    checkWord("frame", {PSM_START, rd ? PSM_OP_READ : PSM_OP_WRITE, phy, rg,
      (rd && phy != PSM_PHY_ADDR) ? 2'b11 : PSM_TA_WRITE, rd ? expData : wd}, seen);
    repeat (8) @(posedge clk);
  endtask

  task automatic scnWriteRead();
    xfer(1'b0, 1'b1, PSM_PHY_ADDR, 5'h05, 16'ha5c3, 16'h0);
    checkWord("stored", 32'h0000a5c3, {16'h0, mem[5]});
    xfer(1'b1, 1'b0, PSM_PHY_ADDR, 5'h05, 16'h0, 16'ha5c3);
    checkWord("write count", 32'h1, 32'(wrCount));
  endtask

  task automatic scnStatus();
    // bit 6 of register 1 reads set even though the store holds zero
    xfer(1'b1, 1'b1, PSM_PHY_ADDR, PSM_STATUS_REG, 16'h0, 16'h0040);
  endtask

  task automatic scnForeign();
    xfer(1'b0, 1'b0, 5'h03, 5'h05, 16'h1234, 16'h0);
    checkWord("foreign write", 32'h1, 32'(wrCount));
    xfer(1'b1, 1'b0, 5'h03, 5'h05, 16'h0, 16'hffff);
  endtask

  task automatic scnReset();
    @(posedge clk);
    reqValid <= 1'b1;
    drive(1'b0, 1'b0, PSM_PHY_ADDR, 5'h07, 16'hbeef);
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (60) @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    checkWord("reset lines", 32'h0, {29'h0, link.mdc, link.mdioStaOe, link.mdioPhyOe});
    @(posedge clk);
    resetn <= 1'b1;
    xfer(1'b0, 1'b0, PSM_PHY_ADDR, 5'h09, 16'h0f0f, 16'h0);
    checkWord("aborted", 32'h0, {16'h0, mem[7]});
    checkWord("after reset", 32'h00000f0f, {16'h0, mem[9]});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    closeOut();
  end

  initial
  begin
    resetn = 1'b0;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqPreamble = 1'b0;
    reqPhy = 5'h00;
    reqReg = 5'h00;
    reqWdata = 16'h0000;
    regRdata = 16'h0000;
    mdcPrev = 1'b0;
    inFrame = 1'b0;
    wrCount = 0;
    foreach (mem[i])
      mem[i] = 16'h0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    scnWriteRead();
    scnStatus();
    scnForeign();
    scnReset();
    closeOut();
  end
endmodule

/* psm_assertions.sv */
`timescale 1ns/100ps
module psm_assertions
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdioStaOut,
  input wire logic mdioStaOe,
  input wire logic mdioPhyOut,
  input wire logic mdioPhyOe,
  input wire logic mdio
);
  // phy holds turnaround low plus 16 data bits, 4 clk per bit
  localparam int OE_MIN = 64;
  localparam int OE_MAX = 72;
  logic [7:0] oeCnt_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ====
  // length of each phy drive
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      oeCnt_q <= 8'h00;
    else if (!mdioPhyOe)
      oeCnt_q <= 8'h00;
    else if (oeCnt_q != 8'hff)
      oeCnt_q <= oeCnt_q + 8'h01;
  end

  // ====
  // checks
  no_contend_a: assert property (!(mdioStaOe && mdioPhyOe))
    else $error("both ends drive the data line");
  phy_after_sta_a: assert property ($rose(mdioPhyOe) |-> $past(!mdioStaOe))
    else $error("phy drives before station released");
  ta_low_a: assert property ($rose(mdioPhyOe) |-> !mdioPhyOut)
    else $error("phy turnaround bit not low");
  mdc_high_a: assert property ($rose(mdc) |=> mdc)
    else $error("management clock high phase too short");
  mdc_low_a: assert property ($fell(mdc) |=> !mdc)
    else $error("management clock low phase too short");
  sta_setup_a: assert property ($rose(mdc) |-> $stable(mdioStaOut))
    else $error("station changed data at clock rise");
  phy_hold_a: assert property ($fell(mdioPhyOe) |-> oeCnt_q >= OE_MIN && oeCnt_q <= OE_MAX)
    else $error("phy drive length wrong");
  phy_idle_a: assert property (oeCnt_q <= 8'(OE_MAX))
    else $error("phy drives while link idle");
  phy_setup_a: assert property ($rose(mdc) |-> $stable(mdioPhyOut))
    else $error("phy changed data at clock rise");
  line_pullup_a: assert property (!mdioStaOe && !mdioPhyOe |-> mdio)
    else $error("released line not high");
  reset_quiet_a: assert property ($rose(resetn) |-> !mdioStaOe && !mdioPhyOe && !mdc)
    else $error("link not quiet after reset");

  cover property ($rose(mdioPhyOe));
  cover property ($fell(mdioStaOe));
  cover property ($rose(resetn));
endmodule

/* psm_link_if.sv */
`timescale 1ns/100ps
interface psm_link_if;
  logic mdc;
  logic mdioStaOut;
  logic mdioStaOe;
  logic mdioPhyOut;
  logic mdioPhyOe;
  logic mdio;

  // pull-up holds the line high when nobody drives it
  assign mdio = mdioStaOe ? mdioStaOut : (mdioPhyOe ? mdioPhyOut : 1'b1);

  modport station
  (
    output mdc,
    output mdioStaOut,
    output mdioStaOe,
    input mdio
  );

  modport phy
  (
    input mdc,
    output mdioPhyOut,
    output mdioPhyOe,
    input mdio
  );
endinterface

/* psm_phy.sv */
`timescale 1ns/100ps
// Contract
// - station keeps mdc at most 12.5 MHz
// - phy answers only at address 10h
// - fields sent preamble through idle in order
// - station sends each frame without pause
// - preamble optional; register 1 bit 6 set
// - frame starts with pattern 01
// - opcode 10 reads, 01 writes
// - phy address five bits, msb first
// - register address five bits, msb first
// - station drives write turnaround 1 then 0
// - phy read turnaround: float, then low
// - sixteen data bits, bit 15 first
// - both release data line when idle
module psm_phy
(
  input wire logic clk,
  input wire logic resetn,
  psm_link_if.phy link,
  output logic regWrite,
  output logic [4:0] regAddr,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata
);
  import psm_pkg::*;

  typedef enum logic [2:0]
  {
    PSM_P_IDLE = 3'b000,
    PSM_P_CMD = 3'b001,
    PSM_P_TA = 3'b010,
    PSM_P_RDATA = 3'b011,
    PSM_P_WDATA = 3'b100
  } psm_p_state_t;

  // ==========================================
  // synchronisers
  logic mdcS1_q, mdcS2_q, mdcS3_q;
  logic mdioS1_q, mdioS2_q;
  logic mdcRise;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdcS1_q <= 1'b0;
      mdcS2_q <= 1'b0;
      mdcS3_q <= 1'b0;
      mdioS1_q <= 1'b1;
      mdioS2_q <= 1'b1;
    end
    else
    begin
      mdcS1_q <= link.mdc;
      mdcS2_q <= mdcS1_q;
      mdcS3_q <= mdcS2_q;
      mdioS1_q <= link.mdio;
      mdioS2_q <= mdioS1_q;
    end
  end

  assign mdcRise = mdcS2_q & ~mdcS3_q;

  // ==========================================
  // frame receiver
  psm_p_state_t state_q;
  logic [13:0] shift_q;
  logic [15:0] dataSh_q;
  logic [4:0] cnt_q;
  logic [1:0] last2_q;
  logic isRead_q;
  logic oe_q, out_q;
  logic [13:0] cmd;
  logic cmdOk;
  logic [15:0] rdVal;

  assign cmd = {shift_q[12:0], mdioS2_q};
  // a mismatched address or opcode drops back to idle and stays off the line
  assign cmdOk = (cmd[9:5] == PSM_PHY_ADDR) &&
    (cmd[11:10] == PSM_OP_READ || cmd[11:10] == PSM_OP_WRITE);

  always_comb
  begin
    rdVal = regRdata;
    if (regAddr == PSM_STATUS_REG)
    begin
      rdVal[PSM_PRE_SUPPRESS_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= PSM_P_IDLE;
      shift_q <= '0;
      dataSh_q <= '0;
      cnt_q <= '0;
      last2_q <= 2'b11;
      isRead_q <= 1'b0;
      regAddr <= '0;
      regWdata <= '0;
      regWrite <= 1'b0;
    end
    else
    begin
      regWrite <= 1'b0;
      if (mdcRise)
      begin
        unique case (state_q)
          PSM_P_IDLE:
          begin
            last2_q <= {last2_q[0], mdioS2_q};
            // start pattern needs no preamble before it
            if ({last2_q[0], mdioS2_q} == PSM_START)
            begin
              state_q <= PSM_P_CMD;
              cnt_q <= '0;
              last2_q <= 2'b11;
            end
          end
          PSM_P_CMD:
          begin
            shift_q <= cmd;
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == 5'(2 + 2 * PSM_ADDR_W - 1))
            begin
              if (cmdOk)
              begin
                isRead_q <= (cmd[11:10] == PSM_OP_READ);
                regAddr <= cmd[4:0];
                state_q <= PSM_P_TA;
              end
              else
              begin
                state_q <= PSM_P_IDLE;
              end
              cnt_q <= '0;
            end
          end
          PSM_P_TA:
          begin
            cnt_q <= cnt_q + 5'd1;
            if (cnt_q == 5'd0 && isRead_q)
            begin
              dataSh_q <= rdVal;
            end
            if (cnt_q == 5'd1)
            begin
              cnt_q <= '0;
              state_q <= isRead_q ? PSM_P_RDATA : PSM_P_WDATA;
            end
          end
          PSM_P_RDATA:
          begin
            cnt_q <= cnt_q + 5'd1;
            dataSh_q <= {dataSh_q[14:0], 1'b0};
            if (cnt_q == 5'(PSM_DATA_W - 1))
            begin
              state_q <= PSM_P_IDLE;
            end
          end
          PSM_P_WDATA:
          begin
            cnt_q <= cnt_q + 5'd1;
            dataSh_q <= {dataSh_q[14:0], mdioS2_q};
            if (cnt_q == 5'(PSM_DATA_W - 1))
            begin
              regWdata <= {dataSh_q[14:0], mdioS2_q};
              regWrite <= 1'b1;
              state_q <= PSM_P_IDLE;
            end
          end
          default:
          begin
            state_q <= PSM_P_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================
  // line driver, updated just after each detected mdc rise; the fall is seen too late
  // through the synchroniser to settle a bit before the following rise
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oe_q <= 1'b0;
      out_q <= 1'b1;
    end
    else if (mdcRise)
    begin
      if (state_q == PSM_P_TA && cnt_q == 5'd0 && isRead_q)
      begin
        oe_q <= 1'b1;
        out_q <= 1'b0;
      end
      else if (state_q == PSM_P_TA && cnt_q == 5'd1 && isRead_q)
      begin
        oe_q <= 1'b1;
        out_q <= dataSh_q[15];
      end
      else if (state_q == PSM_P_RDATA && cnt_q != 5'(PSM_DATA_W - 1))
      begin
        // shift register moves on this same edge, so the next bit is still one down
        oe_q <= 1'b1;
        out_q <= dataSh_q[14];
      end
      else
      begin
        oe_q <= 1'b0;
        out_q <= 1'b1;
      end
    end
  end

  assign link.mdioPhyOe = oe_q;
  assign link.mdioPhyOut = out_q;
endmodule

/* psm_pkg.sv */
package psm_pkg;
  // ==========================================
  // frame layout
  localparam logic [1:0] PSM_START = 2'b01;
  localparam logic [1:0] PSM_OP_READ = 2'b10;
  localparam logic [1:0] PSM_OP_WRITE = 2'b01;
  localparam logic [1:0] PSM_TA_WRITE = 2'b10;
  localparam int PSM_ADDR_W = 5;
  localparam int PSM_DATA_W = 16;
  localparam logic [4:0] PSM_PHY_ADDR = 5'h10;
  localparam int PSM_PREAMBLE_BITS = 32;
  // bit 6 of register 1 reports preamble suppression
  localparam logic [4:0] PSM_STATUS_REG = 5'h01;
  localparam int PSM_PRE_SUPPRESS_BIT = 6;
  // ==========================================
  // timing
  localparam int PSM_CLK_MHZ = 40;
  localparam int PSM_MDC_MAX_KHZ = 12500;
  // half period in clk cycles, rounded up so the mdc rate stays at or below the limit
  localparam int PSM_MDC_HALF =
    (PSM_CLK_MHZ * 1000 + 2 * PSM_MDC_MAX_KHZ - 1) / (2 * PSM_MDC_MAX_KHZ);
  localparam logic [3:0] PSM_MDC_HALF_CNT = 4'(PSM_MDC_HALF);
  localparam int PSM_CMD_BITS = 14;
endpackage

/* psm_station.sv */
`timescale 1ns/100ps
module psm_station
(
  input wire logic clk,
  input wire logic resetn,
  psm_link_if.station link,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic reqPreamble,
  input wire logic [4:0] reqPhy,
  input wire logic [4:0] reqReg,
  input wire logic [15:0] reqWdata,
  output logic rspValid,
  output logic [15:0] rspRdata
);
  import psm_pkg::*;

  typedef enum logic [1:0]
  {
    PSM_S_IDLE = 2'b00,
    PSM_S_SEND = 2'b01,
    PSM_S_DONE = 2'b10
  } psm_s_state_t;

  // ==========================================
  // mdc divider
  logic [3:0] div_q;
  logic mdc_q, phase;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q <= '0;
      mdc_q <= 1'b0;
    end
    else if (div_q == PSM_MDC_HALF_CNT - 4'd1)
    begin
      div_q <= '0;
      mdc_q <= ~mdc_q;
    end
    else
    begin
      div_q <= div_q + 4'd1;
    end
  end

  assign phase = (div_q == PSM_MDC_HALF_CNT - 4'd1);
  assign link.mdc = mdc_q;

  // mdio back from the line, synchronised
  logic mdioS1_q, mdioS2_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdioS1_q <= 1'b1;
      mdioS2_q <= 1'b1;
    end
    else
    begin
      mdioS1_q <= link.mdio;
      mdioS2_q <= mdioS1_q;
    end
  end

  // ==========================================
  // frame sequencer: drive after falling edge, sample just before rising
  psm_s_state_t state_q;
  logic [63:0] frame_q;
  logic [63:0] driveMask_q;
  logic [6:0] bitsLeft_q;
  logic [15:0] rd_q;
  logic oe_q, out_q, isRead_q;

  assign reqReady = (state_q == PSM_S_IDLE);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= PSM_S_IDLE;
      frame_q <= '0;
      driveMask_q <= '0;
      bitsLeft_q <= '0;
      rd_q <= '0;
      oe_q <= 1'b0;
      out_q <= 1'b1;
      isRead_q <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= '0;
    end
    else
    begin
      rspValid <= 1'b0;
      unique case (state_q)
        PSM_S_IDLE:
        begin
          if (reqValid)
          begin
            isRead_q <= reqRead;
            // fields packed msb first in sending order
            frame_q <= {{PSM_PREAMBLE_BITS{1'b1}}, PSM_START,
              reqRead ? PSM_OP_READ : PSM_OP_WRITE, reqPhy, reqReg,
              reqRead ? 2'b11 : PSM_TA_WRITE,
              reqRead ? 16'hffff : reqWdata};
            driveMask_q <= {{(PSM_PREAMBLE_BITS + PSM_CMD_BITS){1'b1}},
              {(2 + PSM_DATA_W){~reqRead}}};
            bitsLeft_q <= reqPreamble ? 7'd64 : 7'(64 - PSM_PREAMBLE_BITS);
            if (!reqPreamble)
            begin
              frame_q[63:32] <= {PSM_START, reqRead ? PSM_OP_READ : PSM_OP_WRITE,
                reqPhy, reqReg, reqRead ? 2'b11 : PSM_TA_WRITE,
                reqRead ? 16'hffff : reqWdata};
              driveMask_q[63:32] <= {{PSM_CMD_BITS{1'b1}}, {(2 + PSM_DATA_W){~reqRead}}};
            end
            state_q <= PSM_S_SEND;
          end
        end
        PSM_S_SEND:
        begin
          // whole frame runs without gaps
          if (phase && mdc_q)
          begin
            oe_q <= driveMask_q[63];
            out_q <= frame_q[63];
            frame_q <= {frame_q[62:0], 1'b1};
            driveMask_q <= {driveMask_q[62:0], 1'b0};
          end
          if (phase && !mdc_q && oe_q | (bitsLeft_q != 7'd64 && bitsLeft_q != 7'd32))
          begin
            rd_q <= {rd_q[14:0], mdioS2_q};
            bitsLeft_q <= bitsLeft_q - 7'd1;
            if (bitsLeft_q == 7'd1)
            begin
              state_q <= PSM_S_DONE;
            end
          end
        end
        PSM_S_DONE:
        begin
          if (phase && mdc_q)
          begin
            oe_q <= 1'b0;
            out_q <= 1'b1;
          end
          // synchroniser shows each bit one rise late, so the last one needs an extra rise
          if (phase && !mdc_q)
          begin
            rspValid <= 1'b1;
            rspRdata <= isRead_q ? {rd_q[14:0], mdioS2_q} : 16'h0000;
            state_q <= PSM_S_IDLE;
          end
        end
        default:
        begin
          state_q <= PSM_S_IDLE;
        end
      endcase
    end
  end

  assign link.mdioStaOe = oe_q;
  assign link.mdioStaOut = out_q;
endmodule
